// ### pkg/break_event_pkg.sv
// package: shared types and constants for the on-chip break event detector
package break_event_pkg;

    // ==========================================================
    // widths and counts
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int PC_CHANNELS = 8;
    localparam int MASK_BITS_W = 4;
    localparam int MASK_BITS_MIN = 1;
    localparam int MASK_BITS_MAX = 15;

    // ==========================================================
    // reset values
    localparam logic [PC_CHANNELS-1:0] PC_ENABLE_RST = 8'h00;
    localparam logic MATCH_RST = 1'b0;

    // ==========================================================
    // enumerations
    typedef enum logic [1:0] {
        DIR_READ_WRITE = 2'b00,
        DIR_READ = 2'b01,
        DIR_WRITE = 2'b10
    } access_dir_t;

    typedef enum logic [1:0] {
        SIZE_ANY = 2'b00,
        SIZE_BYTE = 2'b01,
        SIZE_WORD = 2'b10
    } access_size_t;

    // event kind held by each slot: address match or data access
    typedef enum logic [0:0] {
        EVENT_ADDRESS_MATCH = 1'b0,
        EVENT_DATA_ACCESS = 1'b1
    } data_access_event_type_t;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic valid;
        logic from_dtc;
        logic is_write;
        logic is_word;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } bus_access_t;

    typedef struct packed {
        logic enable;
        logic [ADDR_W-1:0] addr;
        logic addr_mask_en;
        logic [MASK_BITS_W-1:0] addr_mask_bits;
        access_dir_t dir;
        access_size_t size;
        logic data_cmp_en;
        logic [DATA_W-1:0] data_value;
        logic data_mask_en;
        logic [DATA_W-1:0] data_mask;
    } data_event_cfg_t;

endpackage

// ### verilog/pc_match_channel.sv
// one program-counter comparator channel
`timescale 1ns/1ps
module pc_match_channel
    import break_event_pkg::*;
#(
    parameter int AW = ADDR_W
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // configuration
    input wire logic enable,
    input wire logic [AW-1:0] match_addr,
    // fetch stream
    input wire logic fetch_valid,
    input wire logic [AW-1:0] fetch_addr,
    // result
    output logic hit_q
);

    // ==========================================================
    // compare registered so the break lands before the fetched op runs
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            hit_q <= MATCH_RST;
        end else begin
            hit_q <= enable && fetch_valid && (fetch_addr == match_addr);
        end
    end

endmodule // pc_match_channel

// ### verilog/data_access_comparator.sv
// one data-access comparator with optional data compare
`timescale 1ns/1ps
module data_access_comparator
    import break_event_pkg::*;
#(
    parameter bit HAS_DATA_CMP = 1'b1
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // configuration and access
    input wire data_event_cfg_t cfg,
    input wire bus_access_t acc,
    // result
    output logic hit_q
);

    // ==========================================================
    // low address bits to ignore, all ones in the masked positions
    function automatic logic [ADDR_W-1:0] low_mask(input logic [MASK_BITS_W-1:0] n);
        low_mask = ADDR_W'((32'h1 << n) - 32'h1);
    endfunction

    logic addr_ok;
    logic dir_ok;
    logic size_ok;
    logic data_ok;
    logic [ADDR_W-1:0] ign;
    logic [DATA_W-1:0] dmask;
    logic [DATA_W-1:0] width_mask;

    // ==========================================================
    // qualifier terms
    always_comb begin
        ign = cfg.addr_mask_en ? low_mask(cfg.addr_mask_bits) : '0;
        addr_ok = ((acc.addr ^ cfg.addr) & ~ign) == '0;
        case (cfg.dir)
            DIR_READ: dir_ok = !acc.is_write;
            DIR_WRITE: dir_ok = acc.is_write;
            default: dir_ok = 1'b1;
        endcase
        case (cfg.size)
            SIZE_BYTE: size_ok = !acc.is_word;
            SIZE_WORD: size_ok = acc.is_word;
            default: size_ok = 1'b1;
        endcase
        // byte accesses only compare the low lane
        width_mask = acc.is_word ? 16'hFFFF : 16'h00FF;
        // a zero mask means nothing is masked out
        dmask = (cfg.data_mask_en && cfg.data_mask != '0) ? ~cfg.data_mask : 16'hFFFF;
        data_ok = !(HAS_DATA_CMP && cfg.data_cmp_en) ||
            (((acc.data ^ cfg.data_value) & dmask & width_mask) == '0);
    end

    // ==========================================================
    // match pulse, one per qualifying bus cycle
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            hit_q <= MATCH_RST;
        end else begin
            hit_q <= cfg.enable && acc.valid && !acc.from_dtc &&
                addr_ok && dir_ok && size_ok && data_ok;
        end
    end

    chk_disabled_silent: assert property (@(posedge clock) disable iff (!rst_b)
        !$past(cfg.enable) |-> !hit_q)
        else $error("disabled data comparator matched");
    chk_dtc_ignored: assert property (@(posedge clock) disable iff (!rst_b)
        $past(acc.from_dtc) |-> !hit_q)
        else $error("dtc transfer raised a match");
    chk_size_filter: assert property (@(posedge clock) disable iff (!rst_b)
        ($past(cfg.size) == SIZE_WORD && !$past(acc.is_word)) |-> !hit_q)
        else $error("byte access matched a word event");
    chk_dir_filter: assert property (@(posedge clock) disable iff (!rst_b)
        ($past(cfg.dir) == DIR_READ && $past(acc.is_write)) |-> !hit_q)
        else $error("write matched a read-only event");
    chk_valid_pulse: assert property (@(posedge clock) disable iff (!rst_b)
        hit_q |-> $past(acc.valid))
        else $error("match without a bus cycle");

endmodule // data_access_comparator

// ### verilog/onchip_break_event_detector.sv
// top of the on-chip break event detector: pc channels and two data events
`timescale 1ns/1ps

module onchip_break_event_detector
    import break_event_pkg::*;
#(
    parameter int CHANNELS = PC_CHANNELS
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // pc channel configuration
    input wire logic [CHANNELS-1:0] pc_enable,
    input wire logic [CHANNELS-1:0][ADDR_W-1:0] pc_addr,
    input wire logic [CHANNELS-1:0] channel_kind_load,
    // instruction fetch stream
    input wire logic fetch_valid,
    input wire logic [ADDR_W-1:0] fetch_addr,
    // data event configuration
    input wire data_event_cfg_t first_cfg,
    input wire data_event_cfg_t second_cfg,
    // cpu bus data accesses
    input wire bus_access_t bus_acc,
    // results
    output logic [CHANNELS-1:0] pc_hit,
    output logic first_hit,
    output logic second_hit,
    output logic [3:0] pc_enabled_count_q,
    output data_access_event_type_t event_slot_label [CHANNELS+2]
);

    // ==========================================================
    // elaboration check: channel numbering only reaches seven
    if (CHANNELS < 1 || CHANNELS > PC_CHANNELS) begin : g_bad_channels
        $error("channel count out of range");
    end

    logic [CHANNELS-1:0] pc_en_q;
    data_event_cfg_t second_cfg_eff;

    function automatic logic [3:0] count_ones(input logic [CHANNELS-1:0] v);
        count_ones = 4'h0;
        for (int i = 0; i < CHANNELS; i++) begin
            count_ones = count_ones + 4'(v[i]);
        end
    endfunction

    // ==========================================================
    // enable register, loaded each cycle, cleared by reset
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pc_en_q <= PC_ENABLE_RST;
        end else begin
            pc_en_q <= pc_enable;
        end
    end

    // enabled-channel count, visible to the host for its budgeting
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pc_enabled_count_q <= 4'h0;
        end else begin
            pc_enabled_count_q <= count_ones(pc_en_q);
        end
    end

    // ==========================================================
    // slot kind labels: pc channels first, then the two data events
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            event_slot_label[i] = EVENT_ADDRESS_MATCH;
        end
        event_slot_label[CHANNELS] = EVENT_DATA_ACCESS;
        event_slot_label[CHANNELS+1] = EVENT_DATA_ACCESS;
    end

    // ==========================================================
    // pc comparator channels, one per channel, enabled or not
    for (genvar c = 0; c < CHANNELS; c++) begin : g_pc
        pc_match_channel #(
            .AW(ADDR_W)
        ) u_chan (
            .clock(clock),
            .rst_b(rst_b),
            .enable(pc_en_q[c]),
            .match_addr(pc_addr[c]),
            .fetch_valid(fetch_valid),
            .fetch_addr(fetch_addr),
            .hit_q(pc_hit[c])
        );
    end

    // ==========================================================
    // the second event has no data compare path even if asked
    always_comb begin
        second_cfg_eff = second_cfg;
        second_cfg_eff.data_cmp_en = 1'b0;
    end

    data_access_comparator #(
        .HAS_DATA_CMP(1'b1)
    ) u_first (
        .clock(clock),
        .rst_b(rst_b),
        .cfg(first_cfg),
        .acc(bus_acc),
        .hit_q(first_hit)
    );

    data_access_comparator #(
        .HAS_DATA_CMP(1'b0)
    ) u_second (
        .clock(clock),
        .rst_b(rst_b),
        .cfg(second_cfg_eff),
        .acc(bus_acc),
        .hit_q(second_hit)
    );

    // ==========================================================
    // checks
    sequence s_fetch_at(int ch);
        fetch_valid && pc_en_q[ch] && fetch_addr == pc_addr[ch];
    endsequence

    chk_pc_fire: assert property (@(posedge clock) disable iff (!rst_b)
        s_fetch_at(0) |=> pc_hit[0])
        else $error("pc channel 0 missed its address");
    chk_pc_silent: assert property (@(posedge clock) disable iff (!rst_b)
        !pc_en_q[0] |=> !pc_hit[0])
        else $error("disabled pc channel fired");
    chk_pc_count: assert property (@(posedge clock) disable iff (!rst_b)
        pc_enabled_count_q <= 4'(CHANNELS))
        else $error("enabled count above channel count");
    chk_second_nodata: assert property (@(posedge clock) disable iff (!rst_b)
        second_cfg_eff.data_cmp_en == 1'b0)
        else $error("second event has data compare");
    chk_reset_clear: assert property (@(posedge clock)
        !rst_b |=> (pc_en_q == '0 && !first_hit && !second_hit))
        else $error("reset left enables or matches");
    chk_pulse_short: assert property (@(posedge clock) disable iff (!rst_b)
        first_hit && $past(first_hit) |-> $past(bus_acc.valid, 1))
        else $error("first match held without a bus cycle");
    chk_first_default: assert property (@(posedge clock) disable iff (!rst_b)
        ($past(first_cfg.enable) && !$past(first_cfg.data_cmp_en) && $past(bus_acc.valid)
        && !$past(bus_acc.from_dtc) && $past(bus_acc.addr) == $past(first_cfg.addr)
        && $past(first_cfg.dir) == DIR_READ_WRITE && $past(first_cfg.size) == SIZE_ANY)
        |-> first_hit)
        else $error("first event missed an address-only match");

endmodule // onchip_break_event_detector

// ### verification/host_cfg_model.sv
// host configuration model feeding the two data event comparators
`timescale 1ns/1ps
module host_cfg_model
    import break_event_pkg::*;
(
    // settings asked for by the bench
    input wire data_event_cfg_t first_req,
    input wire data_event_cfg_t second_req,
    // settings as the host loads them
    output data_event_cfg_t first_cfg,
    output data_event_cfg_t second_cfg
);
    // ==========================================================
    // host drops combinations it must never load
    always_comb begin
        first_cfg = first_req;
        second_cfg = second_req;
        second_cfg.data_cmp_en = 1'b0;
        if (first_cfg.size == SIZE_WORD) first_cfg.addr[0] = 1'b0;
        if (second_cfg.size == SIZE_WORD) second_cfg.addr[0] = 1'b0;
        if (first_cfg.addr_mask_en) first_cfg.data_mask_en = 1'b0;
    end
endmodule // host_cfg_model

// ### verification/tb.sv
// self-checking bench for the on-chip break event detector
`timescale 1ns/1ps
module tb;
    import break_event_pkg::*;
    logic clock, rst_b, fetch_valid, first_hit, second_hit;
    logic [7:0] pc_enable, channel_kind_load, pc_hit, en_m;
    logic [7:0][ADDR_W-1:0] pc_addr;
    logic [ADDR_W-1:0] fetch_addr, base;
    logic [3:0] pc_enabled_count_q;
    data_event_cfg_t first_req, second_req, first_cfg, second_cfg;
    bus_access_t bus_acc;
    data_access_event_type_t event_slot_label [10];
    logic [9:0] exp_q [$];
    int mismatches, cmp_count;

    onchip_break_event_detector i_dut (.clock(clock), .rst_b(rst_b), .pc_enable(pc_enable),
        .pc_addr(pc_addr), .channel_kind_load(channel_kind_load), .fetch_valid(fetch_valid),
        .fetch_addr(fetch_addr), .first_cfg(first_cfg), .second_cfg(second_cfg),
        .bus_acc(bus_acc), .pc_hit(pc_hit), .first_hit(first_hit), .second_hit(second_hit),
        .pc_enabled_count_q(pc_enabled_count_q), .event_slot_label(event_slot_label));
    host_cfg_model i_host (.first_req(first_req), .second_req(second_req),
        .first_cfg(first_cfg), .second_cfg(second_cfg));

    // ==========================================================
    // clock, 20 ns period
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // ==========================================================
    // checking helpers
    task automatic cmp_hits(input logic [9:0] got, input logic [9:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: hits got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_val(input logic [3:0] got, input logic [3:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: value got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // expected data event outcome, worked out from the qualifiers
    function automatic logic exp_dat(data_event_cfg_t c, bus_access_t a, bit cmp);
        logic [ADDR_W-1:0] m;
        logic [DATA_W-1:0] dm;
        m = c.addr_mask_en ? ADDR_W'((32'h1 << c.addr_mask_bits) - 1) : '0;
        dm = (c.data_mask_en ? ~c.data_mask : 16'hFFFF) & (a.is_word ? 16'hFFFF : 16'h00FF);
        return c.enable && a.valid && !a.from_dtc && ((c.addr ^ a.addr) & ~m) == '0
            && (c.dir == DIR_READ_WRITE || (c.dir == DIR_WRITE) == a.is_write)
            && (c.size == SIZE_ANY || (c.size == SIZE_WORD) == a.is_word)
            && (!(cmp && c.data_cmp_en) || ((c.data_value ^ a.data) & dm) == '0);
    endfunction

    // drive one cycle at the falling edge and note what the next edge must give
    task automatic drive(input logic fv, input logic [ADDR_W-1:0] fa, input bus_access_t a);
        logic [9:0] e;
        fetch_valid = fv;
        fetch_addr = fa;
        bus_acc = a;
        channel_kind_load = 8'($urandom());
        #1;
        for (int c = 0; c < 8; c++) e[c+2] = fv && en_m[c] && pc_addr[c] == fa;
        e[1] = exp_dat(first_cfg, a, 1'b1);
        e[0] = exp_dat(second_cfg, a, 1'b0);
        if (!rst_b) e = '0;
        exp_q.push_back(e);
        en_m = rst_b ? pc_enable : 8'h00; // enable lands one edge later
        @(negedge clock);
    endtask

    // ==========================================================
    // monitor: one note off the queue per rising edge
    always @(posedge clock) begin
        #1;
        if (exp_q.size() > 0) cmp_hits({pc_hit, first_hit, second_hit}, exp_q.pop_front());
    end

    // watchdog sized well past the roughly 140 cycles of stimulus
    initial begin
        #(20 * 5000);
        mismatches++;
        stop_test();
    end

    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(32'hFB04B30B));
        {rst_b, fetch_valid, pc_enable, channel_kind_load, en_m, fetch_addr} = '0;
        {pc_addr, first_req, second_req, bus_acc} = '0;
        mismatches = 0;
        cmp_count = 0;
        @(negedge clock);
        repeat (3) drive(1'b0, '0, '0);
        rst_b = 1'b1;
        for (int i = 0; i < 10; i++) cmp_val(4'(event_slot_label[i]), i < 8 ? 4'h0 : 4'h1);
        // ten definitions in all, well inside the host's budget of 32
        for (int c = 0; c < 8; c++) pc_addr[c] = (ADDR_W'($urandom()) & 20'hFFFF8) | ADDR_W'(c);
        drive(1'b1, pc_addr[0], '0);
        pc_enable = 8'hFF;
        drive(1'b1, pc_addr[0], '0);
        for (int c = 0; c < 8; c++) drive(1'b1, pc_addr[c], '0);
        cmp_val(pc_enabled_count_q, 4'h8);
        drive(1'b0, pc_addr[5], '0);
        pc_enable[3] = 1'b0;
        drive(1'b0, '0, '0);
        drive(1'b1, pc_addr[3], '0);
        cmp_val(pc_enabled_count_q, 4'h7);
        rst_b = 1'b0;
        drive(1'b1, pc_addr[2], '0);
        rst_b = 1'b1;
        drive(1'b1, pc_addr[2], '0);
        drive(1'b1, pc_addr[2], '0);
        // direction and size filters, every pairing, back to back
        base = ADDR_W'($urandom()) & 20'hFFFFE;
        for (int d = 0; d < 3; d++) begin
            for (int s = 0; s < 3; s++) begin
                first_req = '0;
                first_req.enable = 1'b1;
                first_req.addr = base;
                first_req.dir = access_dir_t'(d);
                first_req.size = access_size_t'(s);
                second_req = first_req;
                second_req.enable = (s == 1);
                drive(1'b0, '0, '0);
                // fields: valid, from_dtc, is_write, is_word, addr, data
                for (int w = 0; w < 4; w++) drive(1'b0, '0, {2'b10, w[0], w[1], base, 16'($urandom())});
                drive(1'b0, '0, {2'b11, 1'b1, 1'b1, base, 16'h0000});
            end
        end
        // address mask widths either side of the top edge of the ignored field
        first_req.dir = DIR_READ_WRITE;
        first_req.size = SIZE_ANY;
        first_req.addr_mask_en = 1'b1;
        for (int n = 1; n <= 15; n++) begin
            first_req.addr_mask_bits = 4'(n);
            drive(1'b0, '0, '0);
            drive(1'b0, '0, {2'b10, 2'b00, base ^ ADDR_W'(1 << (n - 1)), 16'h0});
            drive(1'b0, '0, {2'b10, 2'b00, base ^ ADDR_W'(1 << n), 16'h0});
        end
        // data compare, with and without a mask, on the first event; the second event has no data compare
        first_req.addr_mask_en = 1'b0;
        first_req.data_cmp_en = 1'b1;
        first_req.data_value = 16'($urandom());
        second_req = first_req;
        for (int k = 0; k < 4; k++) begin
            first_req.data_mask_en = k[0];
            first_req.data_mask = k[1] ? 16'h00F0 : 16'h0000;
            drive(1'b0, '0, '0);
            drive(1'b0, '0, {2'b10, 2'b01, base, first_req.data_value});
            drive(1'b0, '0, {2'b10, 2'b01, base, first_req.data_value ^ 16'h0010});
            drive(1'b0, '0, {2'b10, 2'b00, base, first_req.data_value ^ 16'h0100});
            drive(1'b0, '0, {2'b10, 2'b00, base, first_req.data_value ^ 16'h0001});
        end
        drive(1'b0, '0, '0);
        drive(1'b0, '0, '0);
        stop_test();
    end
endmodule // tb
